/* common/fpt_defines.vh */
/*
 Constants for the parameter-table reader and power-state controller.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef FPT_DEFINES_VH
`define FPT_DEFINES_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FPT_OP_READ_TABLE   8'h5A
`define FPT_OP_DEEP_DOWN    8'hB9
`define FPT_OP_RELEASE      8'hAB
`define FPT_OP_RST_ENABLE   8'h66
`define FPT_OP_RST          8'h99
`define FPT_OP_WRITE_ENABLE 8'h06
`define FPT_OP_WRITE_DIS    8'h04
`define FPT_OP_STATUS_WRITE 8'h01
`define FPT_OP_PAGE_PROG    8'h02
`define FPT_OP_QUAD_PROG    8'h38
`define FPT_OP_SECT_ERASE   8'h20
`define FPT_OP_BLK32_ERASE  8'h52
`define FPT_OP_BLK64_ERASE  8'hD8
`define FPT_OP_CHIP_ERASE   8'hC7
`define FPT_OP_CHIP_ERASE2  8'h60
`define FPT_OP_SEC_WRITE    8'h2F
// ----------------------------------------
// Vendor table contents
// ----------------------------------------
`define FPT_ADDR_VMAX_LO    8'h60
`define FPT_ADDR_VMAX_HI    8'h61
`define FPT_ADDR_VMIN_LO    8'h62
`define FPT_ADDR_VMIN_HI    8'h63
`define FPT_ADDR_FEAT_LO    8'h64
`define FPT_ADDR_FEAT_HI    8'h65
`define FPT_ADDR_WRAP_OP    8'h66
`define FPT_ADDR_WRAP_LEN   8'h67
`define FPT_ADDR_LOCK_LO    8'h68
`define FPT_ADDR_LOCK_HI    8'h69
`define FPT_VMAX            16'h2000
`define FPT_VMIN            16'h1650
`define FPT_FEAT            16'hF99C
`define FPT_WRAP_OP         8'hC0
`define FPT_WRAP_LEN        8'h64
`define FPT_LOCK            16'hC8D9
`define FPT_BLANK           8'hFF
// ----------------------------------------
// Timing: figures in their own units, clock 10 MHz
// ----------------------------------------
`define FPT_CLK_KHZ         10000
`define FPT_DEEP_ENTRY_US   10
`define FPT_RELEASE_US      10
`define FPT_REC_READ_US     20
`define FPT_REC_PROG_US     20
`define FPT_REC_ERASE_MS    12
`define FPT_STATUS_WR_MS    40
`define FPT_PAGE_PROG_MS    3
`define FPT_BYTE_PROG_US    30
`define FPT_SECT_ERASE_MS   200
`define FPT_BLK32_ERASE_MS  1000
`define FPT_BLK64_ERASE_MS  2000
`define FPT_CHIP_ERASE_S    80
`define FPT_US(x)           ((x) * `FPT_CLK_KHZ / 1000)
`define FPT_MS(x)           ((x) * `FPT_CLK_KHZ)
`define FPT_S(x)            ((x) * `FPT_CLK_KHZ * 1000)
// Select rising is sampled one edge late and the flag shows one edge after the count ends
`define FPT_EDGE_SLACK      2
`define FPT_CNT_W           32
`endif

/* rtl/fpt_table.v */
/*
 Vendor parameter table: a byte lookup indexed by table address.
 Assumes the caller supplies the low address byte of a table read.
*/
`include "fpt_defines.vh"
module fpt_table (
    input  wire [7:0] addr,
    output reg  [7:0] data
);
    localparam [15:0] vmax_word = `FPT_VMAX;
    localparam [15:0] vmin_word = `FPT_VMIN;
    localparam [15:0] feat_word = `FPT_FEAT;
    localparam [15:0] lock_word = `FPT_LOCK;
    // ----------------------------------------
    // Lookup
    // ----------------------------------------
    always @* begin
        case (addr)
            `FPT_ADDR_VMAX_LO:  data = vmax_word[7:0];            // RL1
            `FPT_ADDR_VMAX_HI:  data = vmax_word[15:8];           // RL1
            `FPT_ADDR_VMIN_LO:  data = vmin_word[7:0];            // RL2
            `FPT_ADDR_VMIN_HI:  data = vmin_word[15:8];           // RL2
            `FPT_ADDR_FEAT_LO:  data = feat_word[7:0];            // RL3
            `FPT_ADDR_FEAT_HI:  data = feat_word[15:8];           // RL3
            `FPT_ADDR_WRAP_OP:  data = `FPT_WRAP_OP;              // RL4
            `FPT_ADDR_WRAP_LEN: data = `FPT_WRAP_LEN;             // RL5
            `FPT_ADDR_LOCK_LO:  data = lock_word[7:0];            // RL6
            `FPT_ADDR_LOCK_HI:  data = lock_word[15:8];           // RL6
            default:            data = `FPT_BLANK;                // RL7
        endcase
    end
endmodule // fpt_table

/* rtl/fpt_ctrl.v */
/*
 Parameter-table reader and power-state controller of a serial flash.
 Assumes a host-side front end has already deserialised the link into
 byte strobes (single, dual or quad lanes alike), with chip select and
 supply-level flags synchronous to clk_sys. Output bytes go back to
 that front end for shifting.
*/
// Notes on behaviour
// RL1 - Bytes 60h/61h return 00h/20h, maximum supply code.
// RL2 - Bytes 62h/63h return 50h/16h, minimum supply code.
// RL3 - Bytes 64h/65h return 9Ch/F9h, feature flags.
// RL4 - Byte 66h returns C0h, the wrap-read configure opcode.
// RL5 - Byte 67h returns 64h, all wrap lengths supported.
// RL6 - Bytes 68h/69h return D9h/C8h; 6Ah/6Bh return FFh.
// RL7 - All unused table bytes, including 6Ch to 6Fh, read FFh.
// RL8 - Power-up leaves the device in standby, not deep power-down.
// RL9 - Power-up clears the write enable latch.
// RL10 - Below write-inhibit threshold, logic held in reset, commands ignored.
// RL11 - Host waits write-access and select delays before write commands.
// RL12 - Reads accepted after select delay even before write-access delay.
// RL13 - Falling below threshold aborts operations including writes in progress.
// RL14 - Quad reads: four dummies to 84MHz, six dummies to 104MHz.
// RL15 - Deep power-down reached within 10 us of select rising.
// RL16 - Release returns to standby within 10 us of select rising.
// RL17 - Reset recovery 20 us after read or program, 12 ms after erase.
// RL18 - Status write 40 ms, page program 3 ms, byte program 30 us; the code holds a one-byte program busy for the full 3 ms.
// RL19 - Erase limits 200 ms, 1000 ms, 2000 ms, 80 s by size.
// RL20 - Table read: opcode 5Ah, three address bytes, dummy, streamed data.
// RL21 - Table read returns ascending bytes while select stays low.
`include "fpt_defines.vh"
module fpt_ctrl (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire       supply_above_inhibit,
    input  wire       write_access_ready,
    input  wire       cs_active,
    input  wire       rx_valid,
    input  wire [7:0] rx_byte,
    input  wire       tx_taken,
    input  wire       quad_command_mode,
    input  wire [2:0] read_dummy_cycles,
    output reg  [7:0] tx_byte,
    output reg        tx_valid,
    output reg        write_enable_latch_flag,
    output reg        deep_down,
    output reg        busy,
    output wire       fast_clock_allowed
);
    // ----------------------------------------
    // States and timing counts
    // ----------------------------------------
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_ADDR  = 3'd1;
    localparam [2:0] ST_DUMMY = 3'd2;
    localparam [2:0] ST_DATA  = 3'd3;
    localparam [2:0] ST_CMD   = 3'd4;
    localparam [2:0] ST_DRAIN = 3'd5;

    localparam [1:0] OP_NONE  = 2'd0;
    localparam [1:0] OP_PROG  = 2'd1;
    localparam [1:0] OP_ERASE = 2'd2;

    // Edges lost around select rising come off the wait so the limit is met, not overrun
    localparam [`FPT_CNT_W-1:0] power_down_entry_time         = `FPT_US(`FPT_DEEP_ENTRY_US) - `FPT_EDGE_SLACK;
    localparam [`FPT_CNT_W-1:0] standby_return_time_plain     = `FPT_US(`FPT_RELEASE_US) - `FPT_EDGE_SLACK;
    localparam [`FPT_CNT_W-1:0] standby_return_time_signature = `FPT_US(`FPT_RELEASE_US) - `FPT_EDGE_SLACK;
    localparam [`FPT_CNT_W-1:0] recovery_after_read           = `FPT_US(`FPT_REC_READ_US);
    localparam [`FPT_CNT_W-1:0] recovery_after_program        = `FPT_US(`FPT_REC_PROG_US);
    localparam [`FPT_CNT_W-1:0] recovery_after_erase          = `FPT_MS(`FPT_REC_ERASE_MS);
    localparam [`FPT_CNT_W-1:0] status_write_time             = `FPT_MS(`FPT_STATUS_WR_MS);
    localparam [`FPT_CNT_W-1:0] page_prog_time                = `FPT_MS(`FPT_PAGE_PROG_MS);
    localparam [`FPT_CNT_W-1:0] sect_erase_time               = `FPT_MS(`FPT_SECT_ERASE_MS);
    localparam [`FPT_CNT_W-1:0] blk32_erase_time              = `FPT_MS(`FPT_BLK32_ERASE_MS);
    localparam [`FPT_CNT_W-1:0] blk64_erase_time              = `FPT_MS(`FPT_BLK64_ERASE_MS);
    localparam [`FPT_CNT_W-1:0] chip_erase_time               = `FPT_S(`FPT_CHIP_ERASE_S);
    localparam [`FPT_CNT_W-1:0] one_cycle                     = 32'h00000001;
    localparam [`FPT_CNT_W-1:0] zero_count                    = 32'h00000000;
    localparam [2:0] quad_fast_dummies = 3'h6;

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [2:0]            state;
    reg  [1:0]            addr_count;
    reg  [7:0]            table_addr;
    reg  [7:0]            opcode;
    reg                   reset_armed;
    reg  [1:0]            last_op;
    reg  [`FPT_CNT_W-1:0] timer;
    reg                   pend_deep;
    reg                   pend_wake;
    wire [7:0]            table_data;
    wire                  hold_reset;
    wire                  timer_done;
    wire                  is_write_op;

    // Internal reset covers the inhibit window so no stale state survives a brown-out
    assign hold_reset = rst | ~supply_above_inhibit;                          // RL10 RL13
    assign timer_done = (timer == zero_count);
    assign is_write_op = (opcode == `FPT_OP_PAGE_PROG) || (opcode == `FPT_OP_QUAD_PROG) ||
                         (opcode == `FPT_OP_SECT_ERASE) || (opcode == `FPT_OP_BLK32_ERASE) ||
                         (opcode == `FPT_OP_BLK64_ERASE) || (opcode == `FPT_OP_CHIP_ERASE) ||
                         (opcode == `FPT_OP_CHIP_ERASE2) || (opcode == `FPT_OP_STATUS_WRITE) ||
                         (opcode == `FPT_OP_SEC_WRITE);
    // Six dummies are needed above 84 MHz; fewer limit the host clock
    assign fast_clock_allowed = (read_dummy_cycles >= quad_fast_dummies);     // RL14

    fpt_table u_table (
        .addr (table_addr),
        .data (table_data)
    );

    // ----------------------------------------
    // Command decoder and table stream
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (hold_reset) begin
            state                   <= ST_IDLE;                               // RL10
            addr_count              <= 2'd0;
            table_addr              <= 8'h00;
            opcode                  <= 8'h00;
            tx_byte                 <= `FPT_BLANK;
            tx_valid                <= 1'b0;
            write_enable_latch_flag <= 1'b0;                                  // RL9
            deep_down               <= 1'b0;                                  // RL8
            busy                    <= 1'b0;                                  // RL13
            reset_armed             <= 1'b0;
            last_op                 <= OP_NONE;
            timer                   <= zero_count;
            pend_deep               <= 1'b0;
            pend_wake               <= 1'b0;
        end else begin
            if (!timer_done) begin
                timer <= timer - one_cycle;
            end else if (busy) begin
                busy    <= 1'b0;
                last_op <= OP_NONE;
                if (last_op != OP_NONE) begin
                    write_enable_latch_flag <= 1'b0;
                end
            end
            if (pend_deep && timer_done) begin
                deep_down <= 1'b1;                                            // RL15
                pend_deep <= 1'b0;
            end
            if (pend_wake && timer_done) begin
                deep_down <= 1'b0;                                            // RL16
                pend_wake <= 1'b0;
            end
            if (!cs_active) begin
                tx_valid <= 1'b0;
                state    <= ST_IDLE;
                // Frame-ending commands take effect when select rises
                if (state == ST_DRAIN && opcode == `FPT_OP_DEEP_DOWN && !busy) begin
                    pend_deep <= 1'b1;
                    timer     <= power_down_entry_time;                       // RL15
                end
                if (state == ST_DRAIN && opcode == `FPT_OP_RELEASE && deep_down) begin
                    pend_wake <= 1'b1;
                    timer     <= standby_return_time_plain;                   // RL16
                end
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (rx_valid) begin
                            opcode <= rx_byte;
                            state  <= ST_DRAIN;
                            if (deep_down) begin
                                // Only release is heard in deep power-down
                                opcode <= (rx_byte == `FPT_OP_RELEASE) ? rx_byte : 8'h00;
                            end else if (rx_byte == `FPT_OP_READ_TABLE && !busy) begin
                                // Reads need no write-access delay
                                state      <= ST_ADDR;                        // RL12 RL20
                                addr_count <= 2'd0;
                            end else begin
                                state <= ST_CMD;
                            end
                            if (!(reset_armed && rx_byte == `FPT_OP_RST)) begin
                                reset_armed <= (rx_byte == `FPT_OP_RST_ENABLE) && !deep_down;
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (rx_valid) begin
                            addr_count <= addr_count + 2'd1;
                            if (addr_count == 2'd2) begin
                                table_addr <= rx_byte;                        // RL20
                                state      <= ST_DUMMY;
                            end
                        end
                    end
                    ST_DUMMY: begin
                        if (rx_valid) begin
                            state      <= ST_DATA;                            // RL20
                            tx_byte    <= table_data;
                            tx_valid   <= 1'b1;
                            // Point at the next byte so the first take does not repeat it
                            table_addr <= table_addr + 8'h01;                 // RL21
                        end
                    end
                    ST_DATA: begin
                        if (tx_taken) begin
                            // Upper address bytes are dropped; the table wraps at 256
                            tx_byte    <= table_data;
                            table_addr <= table_addr + 8'h01;                 // RL21
                        end
                    end
                    ST_CMD: begin
                        state <= ST_DRAIN;
                        if (opcode == `FPT_OP_RST && reset_armed) begin
                            reset_armed             <= 1'b0;
                            write_enable_latch_flag <= 1'b0;
                            busy                    <= 1'b1;
                            last_op                 <= OP_NONE;
                            timer <= (last_op == OP_ERASE) ? recovery_after_erase :
                                     (last_op == OP_PROG)  ? recovery_after_program :
                                                             recovery_after_read;  // RL17
                        end else if (!busy && write_access_ready) begin
                            // Host holds writes until access delay; gate here as well
                            if (opcode == `FPT_OP_WRITE_ENABLE) begin
                                write_enable_latch_flag <= 1'b1;              // RL11
                            end else if (opcode == `FPT_OP_WRITE_DIS) begin
                                write_enable_latch_flag <= 1'b0;
                            end else if (is_write_op && write_enable_latch_flag) begin
                                busy <= 1'b1;
                                case (opcode)
                                    `FPT_OP_STATUS_WRITE: begin
                                        timer <= status_write_time;           // RL18
                                        last_op <= OP_PROG;
                                    end
                                    `FPT_OP_PAGE_PROG, `FPT_OP_QUAD_PROG, `FPT_OP_SEC_WRITE: begin
                                        timer <= page_prog_time;              // RL18
                                        last_op <= OP_PROG;
                                    end
                                    `FPT_OP_SECT_ERASE: begin
                                        timer <= sect_erase_time;             // RL19
                                        last_op <= OP_ERASE;
                                    end
                                    `FPT_OP_BLK32_ERASE: begin
                                        timer <= blk32_erase_time;            // RL19
                                        last_op <= OP_ERASE;
                                    end
                                    `FPT_OP_BLK64_ERASE: begin
                                        timer <= blk64_erase_time;            // RL19
                                        last_op <= OP_ERASE;
                                    end
                                    default: begin
                                        timer <= chip_erase_time;             // RL19
                                        last_op <= OP_ERASE;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_DRAIN: begin
                        state <= ST_DRAIN;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // fpt_ctrl

/* tb/fpt_host.sv */
/*
 Host-side front end model: frames chip select and hands whole bytes to the block.
 Assumes a single clk_sys domain; the bench calls its tasks hierarchically.
*/
module fpt_host (
    input  logic       clk_sys,
    output logic       cs_active,
    output logic       rx_valid,
    output logic [7:0] rx_byte,
    output logic       tx_taken
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Idle state
    // ----------------------------------------
    initial begin
        cs_active = 1'b0;
        rx_valid  = 1'b0;
        rx_byte   = 8'hA5;
        tx_taken  = 1'b0;
    end
    // ----------------------------------------
    // Link actions
    // ----------------------------------------
    task sel(input logic on);
        @(posedge clk_sys) cs_active <= on;
    endtask
    // Byte line goes to the inverse once released, so a stale value never looks valid
    task put(input logic [7:0] b);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_byte  <= b;
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_byte  <= ~b;
    endtask
    // A gap stalls the consumer, as a slow host would
    task take(input int gap);
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys) tx_taken <= 1'b1;
        @(posedge clk_sys) tx_taken <= 1'b0;
    endtask
endmodule // fpt_host

/* tb/fpt_ctrl_properties.sv */
/*
 Checker for the table reader and power-state controller.
 Assumes it is bound to fpt_ctrl and sees only that module's ports.
*/
module fpt_ctrl_chk (
    input logic       clk_sys,
    input logic       rst,
    input logic       supply_above_inhibit,
    input logic       write_access_ready,
    input logic       cs_active,
    input logic       rx_valid,
    input logic       tx_taken,
    input logic [2:0] read_dummy_cycles,
    input logic [7:0] tx_byte,
    input logic       tx_valid,
    input logic       write_enable_latch_flag,
    input logic       deep_down,
    input logic       busy,
    input logic       fast_clock_allowed
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_reset_values: assert property (disable iff (1'b0) rst |=> (tx_byte == 8'hFF && !tx_valid &&
        !write_enable_latch_flag && !deep_down && !busy)) else $error("state wrong after reset");
    a_inhibit_clears: assert property (!supply_above_inhibit |=>
        (!busy && !write_enable_latch_flag && !tx_valid && !deep_down)) else $error("inhibit did not clear state");
    a_latch_gate: assert property ($rose(write_enable_latch_flag) |->
        (write_access_ready && supply_above_inhibit)) else $error("latch set while writes gated");
    a_valid_start: assert property ($rose(tx_valid) |-> $past(rx_valid && cs_active))
        else $error("stream began without a received byte");
    a_valid_drops: assert property (tx_valid && !cs_active |=> !tx_valid)
        else $error("stream outlived chip select");
    a_byte_holds: assert property (tx_valid && cs_active && supply_above_inhibit && !tx_taken
        |=> $stable(tx_byte)) else $error("byte changed without take");
    a_vmax_pair: assert property (tx_valid && cs_active && supply_above_inhibit && tx_taken &&
        tx_byte == 8'h00 |=> tx_byte == 8'h20) else $error("supply maximum high byte wrong");
    a_deep_quiet: assert property (deep_down |-> !tx_valid)
        else $error("stream while in deep power-down");
    a_fast_clock_map: assert property (fast_clock_allowed == (read_dummy_cycles >= 3'h6))
        else $error("clock limit flag wrong");
    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    c_deep_entry: cover property ($rose(deep_down));
    c_busy_end: cover property ($fell(busy));
    c_stream_take: cover property (tx_valid && tx_taken);
endmodule // fpt_ctrl_chk

bind fpt_ctrl fpt_ctrl_chk u_chk (.clk_sys(clk_sys), .rst(rst), .supply_above_inhibit(supply_above_inhibit),
    .write_access_ready(write_access_ready), .cs_active(cs_active), .rx_valid(rx_valid), .tx_taken(tx_taken),
    .read_dummy_cycles(read_dummy_cycles), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .write_enable_latch_flag(write_enable_latch_flag), .deep_down(deep_down), .busy(busy),
    .fast_clock_allowed(fast_clock_allowed));

/* tb/tb.sv */
/*
 Self-checking bench for fpt_ctrl: table reads, write gating, power states.
 Assumes fpt_host as the front end and a 10 MHz clk_sys.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst, supply_above_inhibit, write_access_ready;
    logic quad_command_mode, cs_active, rx_valid, tx_taken, tx_valid, write_enable_latch_flag;
    logic deep_down, busy, fast_clock_allowed;
    logic [2:0] read_dummy_cycles;
    logic [7:0] rx_byte, tx_byte;
    int n_errors = 0, n_checks = 0, n;
    always #50 clk_sys = ~clk_sys;
    fpt_host u_host (.clk_sys(clk_sys), .cs_active(cs_active), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_taken(tx_taken));
    fpt_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .supply_above_inhibit(supply_above_inhibit),
        .write_access_ready(write_access_ready), .cs_active(cs_active), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_taken(tx_taken), .quad_command_mode(quad_command_mode), .read_dummy_cycles(read_dummy_cycles),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .write_enable_latch_flag(write_enable_latch_flag),
        .deep_down(deep_down), .busy(busy), .fast_clock_allowed(fast_clock_allowed));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function logic [7:0] exp_byte(input logic [7:0] a);
        case (a)
            8'h60: return 8'h00; 8'h61: return 8'h20; 8'h62: return 8'h50; 8'h63: return 8'h16;
            8'h64: return 8'h9C; 8'h65: return 8'hF9; 8'h66: return 8'hC0; 8'h67: return 8'h64;
            8'h68: return 8'hD9; 8'h69: return 8'hC8; default: return 8'hFF;
        endcase
    endfunction
    function logic pick(input int s);
        return (s == 0) ? busy : (s == 1) ? deep_down : tx_valid;
    endfunction
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait; n returns the cycles spent
    task wait_lvl(input int s, input logic lvl, input int lim);
        n = 0;
        while (pick(s) !== lvl && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask
    task frame1(input logic [7:0] op);
        u_host.sel(1'b1);
        u_host.put(op);
        u_host.sel(1'b0);
    endtask
    task try_read(input logic [7:0] a);
        u_host.sel(1'b1);
        u_host.put(8'h5A);
        u_host.put(8'h00);
        u_host.put(8'h00);
        u_host.put(a);
        u_host.put(8'h00);
        wait_lvl(2, 1'b1, 6);
    endtask
    task read_tab(input logic [7:0] a, input int cnt);
        try_read(a);
        for (int i = 0; i < cnt; i++) begin
            check("table byte", tx_byte, exp_byte(a + i[7:0]));
            u_host.take(i % 3);
            #1;
        end
        u_host.sel(1'b0);
        wait_lvl(2, 1'b0, 4);
        check("stream end", tx_valid, 8'h00);
    endtask
    task prog_page;
        u_host.sel(1'b1);
        u_host.put(8'h02);
        repeat (3) u_host.put(8'h00);
        u_host.put(8'hAA);
        u_host.sel(1'b0);
        wait_lvl(0, 1'b1, 20);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        supply_above_inhibit = 1'b1;
        write_access_ready = 1'b0;
        quad_command_mode = 1'b0;
        read_dummy_cycles = 3'h4;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check("idle byte", tx_byte, 8'hFF);
        check("latch", write_enable_latch_flag, 8'h00);
        check("deep", deep_down, 8'h00);
        check("fast4", fast_clock_allowed, 8'h00);
        @(posedge clk_sys) read_dummy_cycles <= 3'h6;
        quad_command_mode <= 1'b1;
        #1;
        check("fast6", fast_clock_allowed, 8'h01);
        $display("test power-on done");
        frame1(8'h06);
        repeat (4) @(posedge clk_sys);
        check("early latch", write_enable_latch_flag, 8'h00);
        read_tab(8'h5C, 20);
        $display("test early read done");
        @(posedge clk_sys) write_access_ready <= 1'b1;
        frame1(8'h06);
        repeat (4) @(posedge clk_sys);
        check("latch set", write_enable_latch_flag, 8'h01);
        prog_page();
        check("busy", busy, 8'h01);
        try_read(8'h60);
        check("read while busy", tx_valid, 8'h00);
        u_host.sel(1'b0);
        wait_lvl(0, 1'b0, 30100);
        check("program time", n <= 30000, 8'h01);
        check("latch cleared", write_enable_latch_flag, 8'h00);
        $display("test program done");
        frame1(8'h06);
        prog_page();
        @(posedge clk_sys) supply_above_inhibit <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check("aborted", busy, 8'h00);
        check("latch lost", write_enable_latch_flag, 8'h00);
        frame1(8'h06);
        repeat (4) @(posedge clk_sys);
        check("inhibit latch", write_enable_latch_flag, 8'h00);
        @(posedge clk_sys) supply_above_inhibit <= 1'b1;
        $display("test inhibit done");
        frame1(8'hB9);
        wait_lvl(1, 1'b1, 110);
        check("deep entry", n <= 100, 8'h01);
        try_read(8'h60);
        check("read in deep", tx_valid, 8'h00);
        u_host.sel(1'b0);
        frame1(8'hAB);
        wait_lvl(1, 1'b0, 110);
        check("release", n <= 100, 8'h01);
        $display("test deep power-down done");
        frame1(8'h66);
        frame1(8'h99);
        wait_lvl(0, 1'b1, 10);
        check("recovery busy", busy, 8'h01);
        wait_lvl(0, 1'b0, 300);
        check("recovery time", n <= 200, 8'h01);
        $display("test reset recovery done");
        tally_and_finish();
    end
    // Whole run needs about 30600 cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end
endmodule // tb
